// [cgen_top.sv]
// Purpose: Clock source, oscillator, meter, PLL setup and clock selection
// Assumes: Slow, main and PLL clocks are well below clk_i / 4
// Notes: AXI4-Lite slave, one outstanding write and one read
//
// Operation
// - Status bit per peripheral 2 to 31
// - Enable bit turns main oscillator on/off
// - Stable flag only after start-up elapsed or in bypass
// - Start-up lasts count times eight slow cycles
// - Bypass takes external clock, stable immediately
// - Stable cleared when enable and bypass zero
// - Meter counts main cycles over 16 slow
// - Meter valid only when enabled or bypassed and measured
// - Input divider: 0 off, 1 pass, else divide
// - Lock flag after count slow cycles post-write
// - Factor zero disables PLL, else factor plus one
// - USB ratio pass, half, quarter, 11 reserved
// - Master source: slow, main, reserved, PLL
// - Master scale divides 1 to 64
// - Each programmable clock selects own source
// - Each programmable clock scales 1 to 64
`default_nettype none

module cgen_top #(
	parameter int ADDR_W = 8,
	parameter int NUM_PCK = 2
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic slow_clk_i,
	input wire logic crystal_in_pin_i,
	input wire logic pll_clk_i,
	output logic osc_on_o,
	output logic external_clock_pass_o,
	output logic pll_ref_o,
	output logic pll_on_o,
	output logic [10:0] pll_factor_o,
	output logic [1:0] pll_range_o,
	output logic usb_clk_o,
	output logic mck_o,
	output logic [NUM_PCK-1:0] pck_o,
	output logic [31:0] periph_clk_en_o
);
	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_ARM = 2'b01,
		M_RUN = 2'b10,
		M_DONE = 2'b11
	} cgen_meter_t;

	typedef struct packed {
		logic aw_got;
		logic [ADDR_W-1:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] sy1;
		logic [2:0] sy2;
		logic [2:0] sy3;
		logic [2:0] lvl;
		logic osc_on;
		logic ext_pass;
		logic [7:0] startup_count;
		logic [10:0] su_cnt;
		logic osc_stable_flag;
		cgen_meter_t mstate;
		logic [4:0] win;
		logic [15:0] mcnt;
		logic [15:0] measured_freq_count;
		logic measurement_valid;
		logic [7:0] pll_div;
		logic [5:0] lock_wait_count;
		logic [1:0] pll_range;
		logic [10:0] pll_factor;
		logic [1:0] usb_clock_ratio;
		logic pll_on;
		logic [5:0] lock_left;
		logic lock;
		logic [7:0] ref_cnt;
		logic pll_ref;
		logic [1:0] usb_cnt;
		logic usb_clk;
		logic [NUM_PCK:0][1:0] clock_source_sel;
		logic [NUM_PCK:0][2:0] clock_scale_sel;
		logic [31:0] peripheral_clock_bit;
	} cgen_st_t;

	cgen_st_t r, nxt;
	logic [2:0] evt;
	logic [2:0] rise;
	logic wr_fire;
	logic pll_write;
	logic [31:0] cur;
	logic [31:0] wval;
	logic [10:0] su_target;
	logic [NUM_PCK:0] div_clk;
	logic [NUM_PCK:0] div_rdy;

	// ****************************************
	// Register read mux
	// ****************************************
	function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			ADDR_W'(cgen_pkg::OFS_PERIPH_CTRL),
			ADDR_W'(cgen_pkg::OFS_PERIPH_STATE): v = r.peripheral_clock_bit;
			ADDR_W'(cgen_pkg::OFS_OSC_SETUP): begin
				v[cgen_pkg::OSC_ON_BIT] = r.osc_on;
				v[cgen_pkg::EXT_PASS_BIT] = r.ext_pass;
				v[cgen_pkg::STARTUP_LSB +: 8] = r.startup_count;
			end
			ADDR_W'(cgen_pkg::OFS_FREQ_METER): begin
				v[15:0] = r.measured_freq_count;
				v[cgen_pkg::MEAS_VALID_BIT] = r.measurement_valid;
			end
			ADDR_W'(cgen_pkg::OFS_PLL_SETUP): begin
				v[cgen_pkg::PLL_DIV_LSB +: 8] = r.pll_div;
				v[cgen_pkg::PLL_LC_LSB +: 6] = r.lock_wait_count;
				v[cgen_pkg::PLL_OUT_LSB +: 2] = r.pll_range;
				v[cgen_pkg::PLL_MUL_LSB +: 11] = r.pll_factor;
				v[cgen_pkg::PLL_USB_LSB +: 2] = r.usb_clock_ratio;
			end
			ADDR_W'(cgen_pkg::OFS_POWER_STATUS): begin
				v[cgen_pkg::ST_STABLE_BIT] = r.osc_stable_flag;
				v[cgen_pkg::ST_LOCK_BIT] = r.lock;
				v[cgen_pkg::ST_MCK_BIT] = div_rdy[0];
				v[cgen_pkg::ST_PCK_LSB +: NUM_PCK] = div_rdy[NUM_PCK:1];
			end
			default: begin
				for (int i = 0; i <= NUM_PCK; i++) begin
					// Index 0 is master only; base minus four must stay undecoded
					if ((i > 0 &&
						a == ADDR_W'(cgen_pkg::OFS_PCK_BASE) + ADDR_W'(4 * (i - 1))) ||
						(i == 0 && a == ADDR_W'(cgen_pkg::OFS_MCK_SETUP))) begin
						v[cgen_pkg::SEL_LSB +: 2] = r.clock_source_sel[i];
						v[cgen_pkg::SCALE_LSB +: 3] = r.clock_scale_sel[i];
					end
				end
			end
		endcase
		return v;
	endfunction : read_word

	function automatic logic known(input logic [ADDR_W-1:0] a);
		logic k;
		k = (a == ADDR_W'(cgen_pkg::OFS_PERIPH_CTRL)) || (a == ADDR_W'(cgen_pkg::OFS_PERIPH_STATE)) ||
			(a == ADDR_W'(cgen_pkg::OFS_OSC_SETUP)) || (a == ADDR_W'(cgen_pkg::OFS_FREQ_METER)) ||
			(a == ADDR_W'(cgen_pkg::OFS_PLL_SETUP)) || (a == ADDR_W'(cgen_pkg::OFS_MCK_SETUP)) ||
			(a == ADDR_W'(cgen_pkg::OFS_POWER_STATUS));
		for (int i = 0; i < NUM_PCK; i++) begin
			k = k || (a == ADDR_W'(cgen_pkg::OFS_PCK_BASE) + ADDR_W'(4 * i));
		end
		return k;
	endfunction : known

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt = r;
		// Pins pass three flops; an edge counts when stages two and three agree
		nxt.sy1 = {pll_clk_i, crystal_in_pin_i, slow_clk_i};
		nxt.sy2 = r.sy1;
		nxt.sy3 = r.sy2;
		evt = (r.sy2 ~^ r.sy3) & (r.sy3 ^ r.lvl);
		rise = evt & r.sy3;
		nxt.lvl = r.lvl ^ evt;

		// AXI write channel
		if (s_axi_awvalid_i && r.awready) begin
			nxt.aw_got = 1'b1;
			nxt.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && r.wready) begin
			nxt.w_got = 1'b1;
			nxt.wdata = s_axi_wdata_i;
			nxt.wstrb = s_axi_wstrb_i;
		end
		if (r.bvalid && s_axi_bready_i) begin
			nxt.bvalid = 1'b0;
		end
		wr_fire = r.aw_got && r.w_got && !r.bvalid;
		cur = read_word(r.awaddr);
		wval = cur;
		for (int b = 0; b < 4; b++) begin
			if (r.wstrb[b]) begin
				wval[8*b +: 8] = r.wdata[8*b +: 8];
			end
		end
		pll_write = wr_fire && (r.awaddr == ADDR_W'(cgen_pkg::OFS_PLL_SETUP));
		if (wr_fire) begin
			nxt.aw_got = 1'b0;
			nxt.w_got = 1'b0;
			nxt.bvalid = 1'b1;
			nxt.bresp = known(r.awaddr) ? cgen_pkg::RESP_OKAY : cgen_pkg::RESP_SLVERR;
			case (r.awaddr)
				ADDR_W'(cgen_pkg::OFS_PERIPH_CTRL): begin
					nxt.peripheral_clock_bit = {wval[31:cgen_pkg::PERIPH_LSB], 2'b00};
				end
				ADDR_W'(cgen_pkg::OFS_OSC_SETUP): begin
					nxt.osc_on = wval[cgen_pkg::OSC_ON_BIT];
					nxt.ext_pass = wval[cgen_pkg::EXT_PASS_BIT];
					nxt.startup_count = wval[cgen_pkg::STARTUP_LSB +: 8];
				end
				ADDR_W'(cgen_pkg::OFS_PLL_SETUP): begin
					nxt.pll_div = wval[cgen_pkg::PLL_DIV_LSB +: 8];
					nxt.lock_wait_count = wval[cgen_pkg::PLL_LC_LSB +: 6];
					nxt.pll_range = wval[cgen_pkg::PLL_OUT_LSB +: 2];
					nxt.pll_factor = wval[cgen_pkg::PLL_MUL_LSB +: 11];
					nxt.usb_clock_ratio = wval[cgen_pkg::PLL_USB_LSB +: 2];
				end
				default: begin
					for (int i = 0; i <= NUM_PCK; i++) begin
						if ((i > 0 &&
							r.awaddr == ADDR_W'(cgen_pkg::OFS_PCK_BASE) + ADDR_W'(4 * (i - 1))) ||
							(i == 0 && r.awaddr == ADDR_W'(cgen_pkg::OFS_MCK_SETUP))) begin
							nxt.clock_source_sel[i] = wval[cgen_pkg::SEL_LSB +: 2];
							nxt.clock_scale_sel[i] = wval[cgen_pkg::SCALE_LSB +: 3];
						end
					end
				end
			endcase
		end
		nxt.awready = !nxt.aw_got && !nxt.bvalid;
		nxt.wready = !nxt.w_got && !nxt.bvalid;

		// AXI read channel
		if (r.rvalid && s_axi_rready_i) begin
			nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && r.arready) begin
			nxt.rvalid = 1'b1;
			nxt.rdata = read_word(s_axi_araddr_i);
			nxt.rresp = known(s_axi_araddr_i) ? cgen_pkg::RESP_OKAY : cgen_pkg::RESP_SLVERR;
		end
		nxt.arready = !nxt.rvalid;

		// Oscillator start-up
		su_target = {r.startup_count, 3'b000};
		if (!r.osc_on && !r.ext_pass) begin
			nxt.osc_stable_flag = 1'b0;
			nxt.su_cnt = 11'h000;
		end else if (r.ext_pass) begin
			nxt.osc_stable_flag = 1'b1;
		end else if (!r.osc_stable_flag) begin
			if (r.su_cnt >= su_target) begin
				nxt.osc_stable_flag = 1'b1;
			end else if (rise[0]) begin
				nxt.su_cnt = r.su_cnt + 11'h001;
			end
		end

		// Frequency meter, one measurement per enable
		case (r.mstate)
			M_IDLE: begin
				if (r.osc_on || r.ext_pass) begin
					nxt.mstate = M_ARM;
				end
			end
			M_ARM: begin
				if (rise[0]) begin
					nxt.mstate = M_RUN;
					nxt.win = 5'h00;
					nxt.mcnt = 16'h0000;
				end
			end
			M_RUN: begin
				if (rise[1] && r.mcnt != 16'hffff) begin
					nxt.mcnt = r.mcnt + 16'h0001;
				end
				if (rise[0]) begin
					nxt.win = r.win + 5'h01;
					if (r.win == cgen_pkg::METER_LAST) begin
						nxt.mstate = M_DONE;
						nxt.measured_freq_count = r.mcnt + 16'(rise[1] && r.mcnt != 16'hffff);
						nxt.measurement_valid = 1'b1;
					end
				end
			end
			M_DONE: begin
			end
			default: nxt.mstate = M_IDLE;
		endcase
		if (!r.osc_on && !r.ext_pass) begin
			nxt.mstate = M_IDLE;
			nxt.measurement_valid = 1'b0;
		end

		// PLL lock wait, restarted by every PLL setup write
		if (pll_write) begin
			nxt.lock = 1'b0;
			nxt.lock_left = wval[cgen_pkg::PLL_LC_LSB +: 6];
		end else if (!r.lock) begin
			if (r.lock_left == 6'h00) begin
				nxt.lock = 1'b1;
			end else if (rise[0]) begin
				nxt.lock_left = r.lock_left - 6'h01;
			end
		end
		nxt.pll_on = (nxt.pll_factor != 11'h000);

		// PLL input divider on both main clock edges
		if (r.pll_div == 8'h00) begin
			nxt.pll_ref = 1'b0;
			nxt.ref_cnt = 8'h00;
		end else if (r.pll_div == 8'h01) begin
			nxt.pll_ref = r.lvl[1];
		end else if (evt[1]) begin
			if (r.ref_cnt >= r.pll_div - 8'h01) begin
				nxt.ref_cnt = 8'h00;
				nxt.pll_ref = !r.pll_ref;
			end else begin
				nxt.ref_cnt = r.ref_cnt + 8'h01;
			end
		end

		// USB divider; reserved code or idle PLL holds low
		if (!r.pll_on || r.usb_clock_ratio == cgen_pkg::USB_DIV1 + 2'h3) begin
			nxt.usb_clk = 1'b0;
			nxt.usb_cnt = 2'h0;
		end else if (r.usb_clock_ratio == cgen_pkg::USB_DIV1) begin
			nxt.usb_clk = r.lvl[2];
		end else if (evt[2]) begin
			if (r.usb_cnt >= ((r.usb_clock_ratio == cgen_pkg::USB_DIV2) ? 2'h1 : 2'h3)) begin
				nxt.usb_cnt = 2'h0;
				nxt.usb_clk = !r.usb_clk;
			end else begin
				nxt.usb_cnt = r.usb_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= '0;
			r.lock_wait_count <= cgen_pkg::PLL_LC_RST;
			r.lock_left <= cgen_pkg::PLL_LC_RST;
		end else begin
			r <= nxt;
		end
	end

	// ****************************************
	// Master and programmable clock dividers
	// ****************************************
	// Index 0 is the master clock, the rest programmable outputs
	for (genvar g = 0; g <= NUM_PCK; g++) begin : g_div
		cgen_div u_div (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.evt_i(evt),
			.src_sel_i(r.clock_source_sel[g]),
			.scale_i(r.clock_scale_sel[g]),
			.clk_o(div_clk[g]),
			.ready_o(div_rdy[g])
		);
	end

	assign s_axi_awready_o = r.awready;
	assign s_axi_wready_o = r.wready;
	assign s_axi_bvalid_o = r.bvalid;
	assign s_axi_bresp_o = r.bresp;
	assign s_axi_arready_o = r.arready;
	assign s_axi_rvalid_o = r.rvalid;
	assign s_axi_rdata_o = r.rdata;
	assign s_axi_rresp_o = r.rresp;
	assign osc_on_o = r.osc_on;
	assign external_clock_pass_o = r.ext_pass;
	assign pll_ref_o = r.pll_ref;
	assign pll_on_o = r.pll_on;
	assign pll_factor_o = r.pll_factor;
	assign pll_range_o = r.pll_range;
	assign usb_clk_o = r.usb_clk;
	assign mck_o = div_clk[0];
	assign pck_o = div_clk[NUM_PCK:1];
	assign periph_clk_en_o = r.peripheral_clock_bit;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	bresp_hold_a: assert property (r.bvalid && !s_axi_bready_i |=> r.bvalid && $stable(r.bresp))
		else $error("Write response dropped early");
	unused_zero_a: assert property (r.peripheral_clock_bit[1:0] == 2'b00)
		else $error("Unimplemented peripheral bits set");
	stable_elapsed_a: assert property ($rose(r.osc_stable_flag) && !r.ext_pass |->
		$past(r.su_cnt) >= $past(su_target)) else $error("Stable before start-up elapsed");
	bypass_stable_a: assert property (r.ext_pass |=> r.osc_stable_flag)
		else $error("Bypass did not raise stable");
	both_off_a: assert property (!r.osc_on && !r.ext_pass |=> !r.osc_stable_flag)
		else $error("Stable kept with oscillator off");
	meter_valid_a: assert property (r.measurement_valid |->
		$past(r.osc_on || r.ext_pass)) else $error("Meter valid while oscillator off");
	lock_clear_a: assert property (pll_write |=>
		!r.lock && r.lock_left == $past(wval[cgen_pkg::PLL_LC_LSB +: 6]))
		else $error("Lock not restarted by write");
	div_zero_a: assert property ((r.pll_div == 8'h00)[*2] |-> !r.pll_ref)
		else $error("Input divider output not held low");
	usb_rsvd_a: assert property ((r.usb_clock_ratio == 2'h3)[*2] |-> !r.usb_clk)
		else $error("Reserved USB ratio produced a clock");
	pll_off_a: assert property (r.pll_factor == 11'h000 |-> !r.pll_on)
		else $error("PLL on with zero factor");
endmodule : cgen_top

`default_nettype wire

// [cgen_div.sv]
// Purpose: Register package and glitch-free selectable clock divider
// Assumes: Source clocks arrive as both-edge event strobes on clk_i
// Notes: One divider per master or programmable clock output
`default_nettype none

package cgen_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_PERIPH_CTRL = 8'h10;
	localparam logic [7:0] OFS_PERIPH_STATE = 8'h14;
	localparam logic [7:0] OFS_OSC_SETUP = 8'h20;
	localparam logic [7:0] OFS_FREQ_METER = 8'h24;
	localparam logic [7:0] OFS_PLL_SETUP = 8'h2c;
	localparam logic [7:0] OFS_MCK_SETUP = 8'h30;
	localparam logic [7:0] OFS_PCK_BASE = 8'h40;
	localparam logic [7:0] OFS_POWER_STATUS = 8'h68;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int OSC_ON_BIT = 0;
	localparam int EXT_PASS_BIT = 1;
	localparam int STARTUP_LSB = 8;
	localparam int STARTUP_SHIFT = 3;
	localparam int MEAS_VALID_BIT = 16;
	localparam int PLL_DIV_LSB = 0;
	localparam int PLL_LC_LSB = 8;
	localparam int PLL_OUT_LSB = 14;
	localparam int PLL_MUL_LSB = 16;
	localparam int PLL_USB_LSB = 28;
	localparam int SEL_LSB = 0;
	localparam int SCALE_LSB = 2;
	localparam int ST_STABLE_BIT = 0;
	localparam int ST_LOCK_BIT = 2;
	localparam int ST_MCK_BIT = 3;
	localparam int ST_PCK_LSB = 8;
	localparam int PERIPH_LSB = 2;
	localparam logic [5:0] PLL_LC_RST = 6'h3f;
	localparam logic [4:0] METER_LAST = 5'h0f;
	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [1:0] SRC_SLOW = 2'h0;
	localparam logic [1:0] SRC_MAIN = 2'h1;
	localparam logic [1:0] SRC_RSVD = 2'h2;
	localparam logic [1:0] SRC_PLL = 2'h3;
	localparam logic [2:0] SCALE_RSVD = 3'h7;
	localparam logic [1:0] USB_DIV1 = 2'h0;
	localparam logic [1:0] USB_DIV2 = 2'h1;
	localparam logic [1:0] USB_DIV4 = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cgen_pkg

module cgen_div (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [2:0] evt_i,
	input wire logic [1:0] src_sel_i,
	input wire logic [2:0] scale_i,
	output logic clk_o,
	output logic ready_o
);
	typedef struct packed {
		logic [1:0] sel;
		logic [2:0] scale;
		logic [5:0] cnt;
		logic clk;
		logic rdy;
	} cgen_div_st_t;

	cgen_div_st_t r, nxt;
	logic hit;
	logic change;
	logic [5:0] top;

	always_comb begin
		nxt = r;
		hit = (r.sel == cgen_pkg::SRC_SLOW) ? evt_i[0] :
			(r.sel == cgen_pkg::SRC_MAIN) ? evt_i[1] : evt_i[2];
		top = 6'((7'h01 << r.scale) - 7'h01);
		change = (src_sel_i != cgen_pkg::SRC_RSVD) && (scale_i != cgen_pkg::SCALE_RSVD) &&
			({src_sel_i, scale_i} != {r.sel, r.scale});
		nxt.rdy = !change;
		if (hit) begin
			if (r.cnt == top) begin
				nxt.cnt = 6'h00;
				// Switch only at the end of a low phase: low stretches, nothing shortens
				if (!r.clk && change) begin
					nxt.sel = src_sel_i;
					nxt.scale = scale_i;
				end else begin
					nxt.clk = !r.clk;
				end
			end else begin
				nxt.cnt = r.cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end

	assign clk_o = r.clk;
	assign ready_o = r.rdy;

	edge_on_event_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(r.clk != $past(r.clk)) |-> $past(hit)) else $error("Divided clock moved without source edge");
endmodule : cgen_div

`default_nettype wire

// [cgen_top_tb.sv]
// Purpose: Self-checking bench for the clock source and selection block
// Assumes: Source clocks are slow and run off the clk_i grid
// Notes: Clock rates are judged by counting rises over fixed windows
`default_nettype none
module cgen_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, reset_n_i = 0, slow = 0, crystal_in_pin = 0, pllc = 0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0, rdata, pen;
	logic awready, wready, bvalid, arready, rvalid, osc_on, ext_pass, pll_ref, pll_on;
	logic usb_clk, mck;
	logic [1:0] bresp, rresp, prange, pck;
	logic [10:0] factor;
	logic [7:0] mon;
	int n_mismatch = 0, cmp_count = 0, slow_rises = 0;
	realtime last_mck = 0, last_pck = 0;
	// ********
	// Clocks, sources and monitors
	// ********
	always #2 clk_i = ~clk_i;
	initial begin
		#1.1;
		fork
			forever #32 slow = ~slow;
			forever #12 crystal_in_pin = ~crystal_in_pin;
			forever #20 pllc = ~pllc;
		join
	end
	always @(posedge slow) slow_rises++;
	assign mon = {pck[1], slow, crystal_in_pin, pllc, pll_ref, usb_clk, mck, pck[0]};
	// Shortest legal phase is a source phase less sync jitter
	always @(mck) begin
		if (reset_n_i && $realtime - last_mck < 8.0) chk(1'b0, "short master phase");
		last_mck = $realtime;
	end
	always @(pck[0]) begin
		if (reset_n_i && $realtime - last_pck < 8.0) chk(1'b0, "short pck phase");
		last_pck = $realtime;
	end
	cgen_top #(.ADDR_W(8), .NUM_PCK(2)) uut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .slow_clk_i(slow), .crystal_in_pin_i(crystal_in_pin),
		.pll_clk_i(pllc), .osc_on_o(osc_on), .external_clock_pass_o(ext_pass),
		.pll_ref_o(pll_ref), .pll_on_o(pll_on), .pll_factor_o(factor),
		.pll_range_o(prange), .usb_clk_o(usb_clk), .mck_o(mck), .pck_o(pck),
		.periph_clk_en_o(pen)
	);
	// ********
	// Shared tasks
	// ********
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er = cgen_pkg::RESP_OKAY);
		int t;
		t = 0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk_i);
			t++;
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid && t < 100);
		bready <= 0;
		chk(bvalid === 1'b1 && bresp === er, "write response");
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk_i);
			t++;
			if (arready) arvalid <= 0;
		end while (!rvalid && t < 100);
		rready <= 0;
		if (rvalid !== 1'b1) chk(1'b0, "read response missing");
		d = rdata;
		r = rresp;
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string msg);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d === e && r === cgen_pkg::RESP_OKAY, msg);
	endtask : rchk
	task automatic wait_bit(input logic [7:0] a, input int b, input logic v, output int n);
		logic [31:0] d;
		logic [1:0] r;
		int t;
		t = 0;
		do begin
			rd(a, d, r);
			t++;
		end while (d[b] !== v && t < 2000);
		chk(d[b] === v, "flag never reached");
		n = slow_rises;
	endtask : wait_bit
	// Output rises times ratio must match source rises within two output edges
	task automatic rate(input int k, input int j, input int div, input int ncyc, input string msg);
		int a, b;
		logic [7:0] p;
		a = 0;
		b = 0;
		p = mon;
		repeat (ncyc) begin
			@(posedge clk_i);
			a += int'(mon[k] && !p[k]);
			b += int'(mon[j] && !p[j]);
			p = mon;
		end
		chk(div == 0 ? a == 0 : (a * div >= b - 2 * div && a * div <= b + 2 * div), msg);
	endtask : rate
	// ********
	// Scenarios
	// ********
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rchk(cgen_pkg::OFS_OSC_SETUP, 32'h0, "osc reset value");
		rchk(cgen_pkg::OFS_PLL_SETUP, 32'h3f00, "pll reset value");
		rd(8'h04, d, r);
		chk(d === 32'h0 && r === cgen_pkg::RESP_SLVERR, "unmapped read");
		wr(8'h08, 32'hffff_ffff, cgen_pkg::RESP_SLVERR);
		wr(cgen_pkg::OFS_MCK_SETUP, 32'hffff_ffe0);
		wr(8'h3c, 32'h0000_0007, cgen_pkg::RESP_SLVERR);
		rd(8'h3c, d, r);
		chk(d === 32'h0 && r === cgen_pkg::RESP_SLVERR, "hole below programmable slots");
		rchk(cgen_pkg::OFS_MCK_SETUP, 32'h0, "reserved bits");
	endtask : t_regs
	task automatic t_periph();
		wr(cgen_pkg::OFS_PERIPH_CTRL, 32'hffff_ffff);
		rchk(cgen_pkg::OFS_PERIPH_STATE, 32'hffff_fffc, "periph all");
		wr(cgen_pkg::OFS_PERIPH_STATE, 32'h0);
		chk(pen === 32'hffff_fffc, "periph pins, read-only write");
		wr(cgen_pkg::OFS_PERIPH_CTRL, 32'h8000_0005);
		rchk(cgen_pkg::OFS_PERIPH_STATE, 32'h8000_0004, "periph some");
	endtask : t_periph
	task automatic t_osc();
		logic [31:0] d;
		logic [1:0] r;
		int s, n;
		s = slow_rises;
		wr(cgen_pkg::OFS_OSC_SETUP, 32'h0000_0201);
		chk(osc_on === 1'b1, "osc on");
		wait_bit(cgen_pkg::OFS_POWER_STATUS, 0, 1'b1, n);
		chk(n - s >= 16 && n - s <= 18, "startup length");
		wait_bit(cgen_pkg::OFS_FREQ_METER, 16, 1'b1, n);
		rd(cgen_pkg::OFS_FREQ_METER, d, r);
		chk(d[15:0] >= 16'd41 && d[15:0] <= 16'd44, "meter count");
		wr(cgen_pkg::OFS_OSC_SETUP, 32'h0);
		chk(osc_on === 1'b0, "osc off");
		wait_bit(cgen_pkg::OFS_POWER_STATUS, 0, 1'b0, n);
		rd(cgen_pkg::OFS_FREQ_METER, d, r);
		chk(d[16] === 1'b0, "meter valid when off");
		s = slow_rises;
		wr(cgen_pkg::OFS_OSC_SETUP, 32'h2);
		chk(ext_pass === 1'b1 && osc_on === 1'b0, "bypass pins");
		wait_bit(cgen_pkg::OFS_POWER_STATUS, 0, 1'b1, n);
		chk(n - s <= 1, "bypass stable at once");
		wr(cgen_pkg::OFS_OSC_SETUP, 32'h0);
	endtask : t_osc
	task automatic t_pll();
		logic [31:0] d;
		logic [1:0] r;
		int s, n;
		s = slow_rises;
		wr(cgen_pkg::OFS_PLL_SETUP, 32'h0005_0401);
		rd(cgen_pkg::OFS_POWER_STATUS, d, r);
		chk(d[2] === 1'b0, "lock cleared by write");
		wait_bit(cgen_pkg::OFS_POWER_STATUS, 2, 1'b1, n);
		chk(n - s >= 4 && n - s <= 6, "lock wait");
		chk(pll_on === 1'b1 && factor === 11'd5, "pll factor");
		for (int v = 0; v < 4; v++) begin
			wr(cgen_pkg::OFS_PLL_SETUP, 32'h0005_0400 | v);
			rate(3, 5, v, 1600, "input divider");
		end
		for (int u = 0; u < 3; u++) begin
			wr(cgen_pkg::OFS_PLL_SETUP, (u << 28) | 32'h0005_0401);
			rate(2, 4, 1 << u, 1600, "usb ratio");
		end
		wr(cgen_pkg::OFS_PLL_SETUP, 32'h0000_0401);
		chk(pll_on === 1'b0, "factor zero");
		wr(cgen_pkg::OFS_PLL_SETUP, 32'h07ff_8401);
		chk(pll_on === 1'b1 && factor === 11'h7ff && prange === 2'h2, "factor max");
	endtask : t_pll
	task automatic t_sel(input logic [7:0] a, input int rb, input int k);
		int n;
		int src [3] = '{6, 5, 4};
		for (int i = 0; i < 3; i++) begin
			wr(a, (i == 2) ? 32'h3 : i);
			wait_bit(cgen_pkg::OFS_POWER_STATUS, rb, 1'b1, n);
			rate(k, src[i], 1, 1600, "source select");
		end
		wr(a, 32'h1);
		wait_bit(cgen_pkg::OFS_POWER_STATUS, rb, 1'b1, n);
		wr(a, 32'h2);
		rate(k, 5, 1, 1600, "reserved source kept");
		wr(a, 32'h1d);
		rate(k, 5, 1, 1600, "reserved scale kept");
		for (int p = 0; p < 7; p++) begin
			wr(a, (p << 2) | 1);
			wait_bit(cgen_pkg::OFS_POWER_STATUS, rb, 1'b1, n);
			rate(k, 5, 1 << p, 600 + 48 * (1 << p), "scale");
		end
	endtask : t_sel
	task automatic t_pck1();
		int n;
		wr(cgen_pkg::OFS_PCK_BASE + 8'h04, 32'h5);
		wait_bit(cgen_pkg::OFS_POWER_STATUS, cgen_pkg::ST_PCK_LSB + 1, 1'b1, n);
		rate(7, 5, 2, 1600, "second programmable clock");
		rchk(cgen_pkg::OFS_PCK_BASE + 8'h04, 32'h5, "second programmable readback");
	endtask : t_pck1
	// ********
	// Sequence and verdict
	// ********
	task automatic wrap_up();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1;
		repeat (2) @(posedge clk_i);
		t_regs();
		t_periph();
		t_osc();
		t_pll();
		t_sel(cgen_pkg::OFS_MCK_SETUP, cgen_pkg::ST_MCK_BIT, 1);
		t_sel(cgen_pkg::OFS_PCK_BASE, cgen_pkg::ST_PCK_LSB, 0);
		t_pck1();
		wrap_up();
	end
	// Run is near 51k cycles; generous margin before calling it hung
	initial begin
		#380us;
		chk(1'b0, "watchdog expired");
		wrap_up();
	end
endmodule : cgen_top_tb
`default_nettype wire
